// *** pkg/card_cmd_cfg.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz clock, 10 ns period
// Notes:   definitions only
`ifndef CARD_CMD_CFG_SVH
`define CARD_CMD_CFG_SVH

// ----------------------------------------
// command indices
// ----------------------------------------
`define IDX_BLKLEN_SET     6'h10
`define IDX_WRITE_BLOCK    6'h18
`define IDX_MULTI_WRITE    6'h19
`define IDX_CID_PROGRAM    6'h1a
`define IDX_CARD_PROGRAM   6'h1b
`define IDX_PROT_SET       6'h1c
`define IDX_PROT_CLEAR     6'h1d
`define IDX_PROT_QUERY     6'h1e
`define IDX_RESERVED_31    6'h1f
`define IDX_SECT_FIRST     6'h20
`define IDX_SECT_LAST      6'h21
`define IDX_SECT_DESEL     6'h22
`define IDX_GRP_FIRST      6'h23
`define IDX_GRP_LAST       6'h24
`define IDX_GRP_DESEL      6'h25
`define IDX_ERASE          6'h26

// ----------------------------------------
// short response flag positions
// ----------------------------------------
`define RSP_IDLE_BIT       0
`define RSP_ILLEGAL_BIT    2
`define RSP_ERASE_SEQ_BIT  4
`define RSP_ADDR_BIT       5
`define RSP_PARAM_BIT      6

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define BLKLEN_W           12
`define BLKLEN_RESET       12'h200
`define BLKLEN_MAX         32'h0000_0800
`define RECORD_W           16
`define RECORD_BYTES       12'h002
`define RECORD_RESET       16'h0000
`define GRPSZ_LSB          0
`define GRPSZ_W            5
`define SECTOR_SHIFT       6'h09
`define PROT_GROUPS        32
`define PROT_IDX_W         5
`define STAT_BYTES         2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS      10
`define PROG_TIME_NS       2000
`define ERASE_TIME_NS      20000
`define PROG_CYCLES        (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES       (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`define BUSY_CNT_W         12

`endif

// *** pkg/card_cmd_pkg.sv ***
// Purpose: types shared by the command decoder and its bench
// Assumes: card_cmd_cfg.svh holds every number
// Notes:   carriers are packed structs
`include "card_cmd_cfg.svh"

package card_cmd_pkg;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic [5:0]  index;
        logic [31:0] arg;
    } cmd_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [7:0]  data;
    } wr_s;

    typedef struct packed {
        logic        valid;
        logic        groupMode;
        logic        singleSector;
        logic [31:0] first;
        logic [31:0] last;
        logic        deselValid;
        logic [31:0] deselAddr;
    } erase_s;

    // ----------------------------------------
    // control states, gray along idle-data-busy
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_BUSY = 2'b11,
        ST_STAT = 2'b10
    } state_e;

endpackage

// *** sim/card_cmd_props.sv ***
// Purpose: port checker for the command decoder
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/10ps
`include "card_cmd_cfg.svh"

module card_cmd_props (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rst,
    // decoder ports
    input wire card_cmd_pkg::cmd_s   cmdIn,
    input wire card_cmd_pkg::byte_s  dataIn,
    input wire card_cmd_pkg::byte_s  respOut,
    input wire card_cmd_pkg::byte_s  statOut,
    input wire logic                 busy,
    input wire card_cmd_pkg::wr_s    wrOut,
    input wire card_cmd_pkg::erase_s eraseOut,
    input wire logic [`RECORD_W-1:0] cardRecord
);
    import card_cmd_pkg::*;

    // ----------------------------------------
    // busy run length, too long for a repetition
    // ----------------------------------------
    logic [11:0] busyCnt_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            busyCnt_q <= 12'h000;
        end else begin
            busyCnt_q <= busy ? busyCnt_q + 12'h001 : 12'h000;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_respCause;
        respOut.valid |-> $past(cmdIn.valid) && !$past(busy);
    endproperty
    a_respCause: assert property (p_respCause) else $error("reply without taken frame");

    property p_illegal;
        respOut.valid && $past(cmdIn.index) inside {6'h19, 6'h1a, 6'h1f}
            |-> respOut.data == 8'h04 && !busy;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal index reply wrong");

    property p_protBusy;
        respOut.valid && respOut.data == 8'h00
            && $past(cmdIn.index) inside {`IDX_PROT_SET, `IDX_PROT_CLEAR} |-> busy [*8];
    endproperty
    a_protBusy: assert property (p_protBusy) else $error("protect reply without busy");

    property p_busyLen;
        $fell(busy) |-> busyCnt_q == `PROG_CYCLES || busyCnt_q == `ERASE_CYCLES;
    endproperty
    a_busyLen: assert property (p_busyLen) else $error("busy run length wrong");

    property p_eraseCause;
        eraseOut.valid |-> respOut.valid && respOut.data == 8'h00 && busy
            && $past(cmdIn.index) == `IDX_ERASE;
    endproperty
    a_eraseCause: assert property (p_eraseCause) else $error("erase request misplaced");

    property p_status;
        respOut.valid && respOut.data == 8'h00 && $past(cmdIn.index) == `IDX_PROT_QUERY
            |=> statOut.valid [*4] ##1 !statOut.valid;
    endproperty
    a_status: assert property (p_status) else $error("status bytes wrong count");

    property p_wrData;
        wrOut.valid |-> $past(dataIn.valid) && wrOut.data == $past(dataIn.data);
    endproperty
    a_wrData: assert property (p_wrData) else $error("array byte not from host");

    property p_record;
        $changed(cardRecord) |-> $past(dataIn.valid);
    endproperty
    a_record: assert property (p_record) else $error("record changed without data");
endmodule

bind card_spi_write_protect_erase_cmds card_cmd_props chk (
    .clock(clock), .rst(rst), .cmdIn(cmdIn), .dataIn(dataIn), .respOut(respOut),
    .statOut(statOut), .busy(busy), .wrOut(wrOut), .eraseOut(eraseOut),
    .cardRecord(cardRecord)
);

// *** sim/card_host_model.sv ***
// Purpose: host side issuing frames and data bytes
// Assumes: decoder samples on rising edge
// Notes:   idle lines carry the inverse of the last value
`timescale 1ns/10ps

module card_host_model (
    // clock and handshake
    input  wire logic            clock,
    input  wire logic            busy,
    // toward the decoder
    output card_cmd_pkg::cmd_s   cmdIn,
    output card_cmd_pkg::byte_s  dataIn
);
    import card_cmd_pkg::*;

    initial begin
        cmdIn = '0;
        dataIn = '0;
    end

    // bounded so a stuck busy cannot hang the host
    task automatic sendCmd(input logic [5:0] idx, input logic [31:0] arg);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        @(posedge clock);
        #1;
        cmdIn = '{valid: 1'b1, index: idx, arg: arg};
        @(posedge clock);
        #1;
        cmdIn = '{valid: 1'b0, index: ~idx, arg: ~arg};
    endtask

    task automatic sendByte(input logic [7:0] d);
        @(posedge clock);
        #1;
        dataIn = '{valid: 1'b1, data: d};
        @(posedge clock);
        #1;
        dataIn = '{valid: 1'b0, data: ~d};
    endtask
endmodule

// *** sim/tb_card_spi_write_protect_erase_cmds.sv ***
// Purpose: self-checking bench for the command decoder
// Assumes: host model drives frames, 100 MHz clock
// Notes:   table rows first, awkward cases by hand
`timescale 1ns/10ps
`include "card_cmd_cfg.svh"
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_card_spi_write_protect_erase_cmds;
    import card_cmd_pkg::*;

    typedef struct {
        logic [5:0]  idx;
        logic [31:0] arg;
        logic [7:0]  rsp;
    } row_t;

    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    cmd_s                 cmdIn;
    byte_s                dataIn;
    byte_s                respOut;
    byte_s                statOut;
    logic                 busy;
    wr_s                  wrOut;
    erase_s               eraseOut;
    logic [`RECORD_W-1:0] cardRecord;
    int                   mismatches = 0;
    int                   numChecks = 0;
    int                   n;

    row_t rows[12] = '{
        '{`IDX_BLKLEN_SET, 32'h0000_0000, 8'h40},
        '{`IDX_BLKLEN_SET, 32'h0000_0801, 8'h40},
        '{`IDX_BLKLEN_SET, 32'h0000_0800, 8'h00},
        '{`IDX_BLKLEN_SET, 32'h0000_0004, 8'h00},
        '{`IDX_MULTI_WRITE, 32'h0000_0000, 8'h04},
        '{`IDX_CID_PROGRAM, 32'h0000_0000, 8'h04},
        '{`IDX_RESERVED_31, 32'h0000_0000, 8'h04},
        '{`IDX_SECT_FIRST, 32'h0000_0200, 8'h00},
        '{`IDX_SECT_LAST, 32'h0000_0400, 8'h00},
        '{`IDX_SECT_DESEL, 32'h0000_0600, 8'h00},
        '{`IDX_PROT_CLEAR, 32'hffff_ffff, 8'h20},
        '{`IDX_PROT_QUERY, 32'h8000_0000, 8'h20}
    };

    always #5 clock = ~clock;

    card_host_model host (.clock(clock), .busy(busy), .cmdIn(cmdIn), .dataIn(dataIn));

    card_spi_write_protect_erase_cmds uut (
        .clock(clock), .rst(rst), .cmdIn(cmdIn), .dataIn(dataIn), .respOut(respOut),
        .statOut(statOut), .busy(busy), .wrOut(wrOut), .eraseOut(eraseOut),
        .cardRecord(cardRecord)
    );

    task automatic conclude();
        if (mismatches == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic issue(input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] rsp);
        host.sendCmd(idx, arg);
        `CHK(respOut.valid, 1'b1)
        `CHK(respOut.data, rsp)
    endtask

    // counts busy cycles, bounded against a hang
    task automatic waitIdle(output int cnt);
        cnt = 0;
        while (busy !== 1'b0 && cnt < 5000) begin
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask

    task automatic query(input logic [31:0] arg, input logic [31:0] exp);
        logic [31:0] w;
        issue(`IDX_PROT_QUERY, arg, 8'h00);
        for (int b = 0; b < 4; b++) begin
            @(posedge clock);
            #1;
            `CHK(statOut.valid, 1'b1)
            w = {w[23:0], statOut.data};
        end
        `CHK(w, exp)
    endtask

    initial begin
        #(400_000);
        mismatches++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        `CHK(busy, 1'b0) // reset state
        `CHK(cardRecord, 16'h0000) // reset state
        foreach (rows[i]) begin
            issue(rows[i].idx, rows[i].arg, rows[i].rsp);
        end
        // ----------------------------------------
        // block write with length four
        // ----------------------------------------
        issue(`IDX_WRITE_BLOCK, 32'h0000_1000, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host.sendByte(8'ha0 + k[7:0]);
            `CHK(wrOut, {1'b1, 32'h0000_1000 + k, 8'ha0 + k[7:0]})
        end
        @(posedge clock);
        #1;
        waitIdle(n);
        // ----------------------------------------
        // protection groups
        // ----------------------------------------
        issue(`IDX_PROT_SET, 32'h0000_0600, 8'h00);
        waitIdle(n);
        `CHK(n, `PROG_CYCLES)
        query(32'h0000_0600, 32'h8000_0000);
        issue(`IDX_WRITE_BLOCK, 32'h0000_0600, 8'h20);
        issue(`IDX_PROT_SET, 32'h0000_4000, 8'h20);
        issue(`IDX_PROT_SET, 32'h8000_0600, 8'h20);
        issue(`IDX_PROT_CLEAR, 32'h0000_0600, 8'h00);
        query(32'h0000_0000, 32'h0000_0000);
        issue(`IDX_CARD_PROGRAM, 32'h0000_0000, 8'h00);
        host.sendByte(8'h00);
        host.sendByte(8'h01);
        @(posedge clock);
        #1;
        waitIdle(n);
        `CHK(cardRecord, 16'h0001)
        issue(`IDX_PROT_SET, 32'h0000_0600, 8'h00);
        query(32'h0000_0000, 32'h4000_0000);
        // ----------------------------------------
        // erase selections
        // ----------------------------------------
        issue(`IDX_ERASE, 32'hffff_ffff, 8'h00);
        `CHK(eraseOut, {3'b100, 32'h200, 32'h400, 1'b1, 32'h600})
        waitIdle(n);
        `CHK(n, `ERASE_CYCLES)
        issue(`IDX_GRP_FIRST, 32'h0000_0000, 8'h00);
        issue(`IDX_GRP_LAST, 32'h0000_4000, 8'h00);
        issue(`IDX_GRP_DESEL, 32'h0000_2000, 8'h00);
        issue(`IDX_ERASE, 32'hffff_ffff, 8'h00);
        `CHK(eraseOut, {3'b110, 32'h0, 32'h4000, 1'b1, 32'h2000})
        issue(`IDX_ERASE, 32'hffff_ffff, 8'h10);
        `CHK(eraseOut.valid, 1'b0)
        issue(`IDX_SECT_LAST, 32'h0000_0800, 8'h00);
        issue(`IDX_ERASE, 32'hffff_ffff, 8'h00);
        `CHK(eraseOut.singleSector, 1'b1)
        `CHK(eraseOut.last, 32'h0000_0800)
        // ----------------------------------------
        // reset in mid busy
        // ----------------------------------------
        issue(`IDX_PROT_SET, 32'h0000_0000, 8'h00);
        rst = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK(busy, 1'b0) // reset state
        `CHK(cardRecord, 16'h0000) // reset state
        rst = 1'b0;
        query(32'h0000_0000, 32'h0000_0000);
        conclude();
    end
endmodule

// *** verilog/card_spi_write_protect_erase_cmds.sv ***
// Purpose: decoder for write, record program, protect and erase-tag commands
// Assumes: frames arrive already deframed, synchronous to clock
// Notes:   host waits while busy is high before the next frame
//
// Notes on behaviour
// - index 24 takes one block of current length, busy-type reply
// - block length is the last accepted index 16 argument
// - index 27 reprograms the whole 16-bit record, busy-type reply
// - index 28 sets protect bit of addressed group, busy-type reply
// - group size comes from the record's group size field
// - index 29 clears protect bit of addressed group, busy-type reply
// - protect commands decode the argument bits above the sector shift plus group size field
// - index 30 replies plain then sends protect status bits
// - index 32 latches first sector of erase selection
// - index 33 latches last sector, or a single sector alone
// - index 34 removes one sector from the selection
// - index 35 latches first erase group of range
// - index 36 latches last erase group of range
// - index 37 drops one erase group from the selection
// - index 38 erases current selection, busy-type reply
`timescale 1ns/10ps
`include "card_cmd_cfg.svh"

module card_spi_write_protect_erase_cmds (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // command frames and data bytes from host
    input  wire card_cmd_pkg::cmd_s    cmdIn,
    input  wire card_cmd_pkg::byte_s   dataIn,
    // replies to host
    output      card_cmd_pkg::byte_s   respOut,
    output      card_cmd_pkg::byte_s   statOut,
    output      logic                  busy,
    // requests to flash array
    output      card_cmd_pkg::wr_s     wrOut,
    output      card_cmd_pkg::erase_s  eraseOut,
    output      logic [`RECORD_W-1:0]  cardRecord
);
    import card_cmd_pkg::*;
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // groups are a power-of-two number of sectors so no divider is needed
    function automatic logic [31:0] groupOf(input logic [31:0] addr,
                                           input logic [`RECORD_W-1:0] rec);
        logic [5:0] sh;
        sh = `SECTOR_SHIFT + {1'b0, rec[`GRPSZ_LSB +: `GRPSZ_W]};
        groupOf = (sh > 6'h1f) ? 32'h0 : (addr >> sh);
    endfunction

    function automatic logic inRange(input logic [31:0] grp);
        inRange = (grp < `PROT_GROUPS);
    endfunction

    state_e                  state_q;
    state_e                  stateD;
    logic [`BLKLEN_W-1:0]    blkLen_q;
    logic [`BLKLEN_W-1:0]    dataCnt_q;
    logic                    recMode_q;
    logic [31:0]             wrAddr_q;
    logic [`PROT_GROUPS-1:0] protect_q;
    logic [31:0]             statWord_q;
    logic [1:0]              statCnt_q;
    logic [`BUSY_CNT_W-1:0]  busyCnt_q;
    logic [`BUSY_CNT_W-1:0]  busyLoad;
    logic [31:0]             sectFirst_q;
    logic [31:0]             sectLast_q;
    logic [31:0]             grpFirst_q;
    logic [31:0]             grpLast_q;
    logic                    sectFirstOk_q;
    logic                    sectLastOk_q;
    logic                    grpFirstOk_q;
    logic                    grpLastOk_q;
    logic                    deselOk_q;
    logic [31:0]             desel_q;
    logic                    take;
    logic [7:0]              flags;
    logic [31:0]             argGrp;
    logic                    lastByte;

    assign take     = cmdIn.valid && (state_q == ST_IDLE);
    assign argGrp   = groupOf(cmdIn.arg, cardRecord);
    assign lastByte = dataIn.valid &&
                      (dataCnt_q == ((recMode_q ? `RECORD_BYTES : blkLen_q) - 12'h001));

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    always_comb begin
        flags    = 8'h00;
        stateD   = state_q;
        busyLoad = `BUSY_CNT_W'(`PROG_CYCLES);
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    unique case (cmdIn.index)
                        `IDX_BLKLEN_SET: begin
                            if (cmdIn.arg == 32'h0 || cmdIn.arg > `BLKLEN_MAX) begin
                                flags[`RSP_PARAM_BIT] = 1'b1;
                            end
                        end
                        `IDX_WRITE_BLOCK: begin
                            // protected group refuses the block outright
                            if (!inRange(argGrp) || protect_q[argGrp[`PROT_IDX_W-1:0]]) begin
                                flags[`RSP_ADDR_BIT] = 1'b1;
                            end else begin
                                stateD = ST_DATA;
                            end
                        end
                        `IDX_CARD_PROGRAM: stateD = ST_DATA;
                        `IDX_PROT_SET, `IDX_PROT_CLEAR: begin
                            if (!inRange(argGrp)) begin
                                flags[`RSP_ADDR_BIT] = 1'b1;
                            end else begin
                                stateD = ST_BUSY;
                            end
                        end
                        `IDX_PROT_QUERY: begin
                            if (!inRange(argGrp)) begin
                                flags[`RSP_ADDR_BIT] = 1'b1;
                            end else begin
                                stateD = ST_STAT;
                            end
                        end
                        `IDX_MULTI_WRITE, `IDX_CID_PROGRAM, `IDX_RESERVED_31: begin
                            flags[`RSP_ILLEGAL_BIT] = 1'b1;
                        end
                        `IDX_ERASE: begin
                            if (!sectFirstOk_q && !sectLastOk_q &&
                                !grpFirstOk_q && !grpLastOk_q) begin
                                flags[`RSP_ERASE_SEQ_BIT] = 1'b1;
                            end else begin
                                stateD   = ST_BUSY;
                                busyLoad = `BUSY_CNT_W'(`ERASE_CYCLES);
                            end
                        end
                        default: flags = 8'h00;
                    endcase
                end
            end
            ST_DATA: begin
                if (lastByte) begin
                    stateD = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (busyCnt_q == `BUSY_CNT_W'(0)) begin
                    stateD = ST_IDLE;
                end
            end
            ST_STAT: begin
                if (statCnt_q == `STAT_BYTES) begin
                    stateD = ST_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------
    // state and busy timing
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= stateD;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busyCnt_q <= `BUSY_CNT_W'(0);
            busy      <= 1'b0;
        end else begin
            if (state_q != ST_BUSY && stateD == ST_BUSY) begin
                busyCnt_q <= busyLoad - `BUSY_CNT_W'(1);
            end else if (busyCnt_q != `BUSY_CNT_W'(0)) begin
                busyCnt_q <= busyCnt_q - `BUSY_CNT_W'(1);
            end
            busy <= (stateD == ST_BUSY);
        end
    end

    // ----------------------------------------
    // short response
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            respOut <= '0;
        end else begin
            respOut.valid <= take;
            respOut.data  <= flags;
        end
    end

    // ----------------------------------------
    // block length
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            blkLen_q <= `BLKLEN_RESET;
        end else if (take && cmdIn.index == `IDX_BLKLEN_SET && flags == 8'h00) begin
            blkLen_q <= cmdIn.arg[`BLKLEN_W-1:0];
        end
    end

    // ----------------------------------------
    // data phase: block write or record program
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            dataCnt_q  <= `BLKLEN_W'(0);
            recMode_q  <= 1'b0;
            wrAddr_q   <= 32'h0;
            wrOut      <= '0;
            cardRecord <= `RECORD_RESET;
        end else begin
            wrOut.valid <= 1'b0;
            if (take) begin
                dataCnt_q <= `BLKLEN_W'(0);
                recMode_q <= (cmdIn.index == `IDX_CARD_PROGRAM);
                wrAddr_q  <= cmdIn.arg;
            end else if (state_q == ST_DATA && dataIn.valid) begin
                dataCnt_q <= dataCnt_q + `BLKLEN_W'(1);
                if (recMode_q) begin
                    // each byte shifts in at the low end; two bytes replace the whole record
                    cardRecord <= {cardRecord[`RECORD_W-9:0], dataIn.data};
                end else begin
                    wrOut.valid <= 1'b1;
                    wrOut.addr  <= wrAddr_q;
                    wrOut.data  <= dataIn.data;
                    wrAddr_q    <= wrAddr_q + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // write protection bits and status
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            protect_q <= '0;
        end else if (take && inRange(argGrp)) begin
            if (cmdIn.index == `IDX_PROT_SET) begin
                protect_q[argGrp[`PROT_IDX_W-1:0]] <= 1'b1;
            end else if (cmdIn.index == `IDX_PROT_CLEAR) begin
                protect_q[argGrp[`PROT_IDX_W-1:0]] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            statWord_q <= 32'h0;
            statCnt_q  <= 2'h0;
            statOut    <= '0;
        end else begin
            statOut.valid <= 1'b0;
            if (take && cmdIn.index == `IDX_PROT_QUERY) begin
                // bits from the addressed group upward, first group in the msb
                statWord_q <= {<<{protect_q >> argGrp[`PROT_IDX_W-1:0]}};
                statCnt_q  <= 2'h0;
            end else if (state_q == ST_STAT) begin
                statOut.valid <= 1'b1;
                statOut.data  <= statWord_q[31:24];
                statWord_q    <= {statWord_q[23:0], 8'h00};
                statCnt_q     <= statCnt_q + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // erase selection
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            sectFirst_q   <= 32'h0;
            sectLast_q    <= 32'h0;
            grpFirst_q    <= 32'h0;
            grpLast_q     <= 32'h0;
            sectFirstOk_q <= 1'b0;
            sectLastOk_q  <= 1'b0;
            grpFirstOk_q  <= 1'b0;
            grpLastOk_q   <= 1'b0;
            deselOk_q     <= 1'b0;
            desel_q       <= 32'h0;
            eraseOut      <= '0;
        end else begin
            eraseOut.valid <= 1'b0;
            if (take) begin
                unique case (cmdIn.index)
                    `IDX_SECT_FIRST: begin
                        sectFirst_q   <= cmdIn.arg;
                        sectFirstOk_q <= 1'b1;
                    end
                    `IDX_SECT_LAST: begin
                        sectLast_q   <= cmdIn.arg;
                        sectLastOk_q <= 1'b1;
                    end
                    `IDX_GRP_FIRST: begin
                        grpFirst_q   <= cmdIn.arg;
                        grpFirstOk_q <= 1'b1;
                    end
                    `IDX_GRP_LAST: begin
                        grpLast_q   <= cmdIn.arg;
                        grpLastOk_q <= 1'b1;
                    end
                    // one deselect slot; a later one replaces the earlier
                    `IDX_SECT_DESEL, `IDX_GRP_DESEL: begin
                        desel_q   <= cmdIn.arg;
                        deselOk_q <= 1'b1;
                    end
                    `IDX_ERASE: begin
                        if (flags == 8'h00) begin
                            eraseOut.valid        <= 1'b1;
                            eraseOut.groupMode    <= grpFirstOk_q || grpLastOk_q;
                            eraseOut.singleSector <= sectLastOk_q && !sectFirstOk_q;
                            eraseOut.first        <= (grpFirstOk_q || grpLastOk_q) ?
                                                     grpFirst_q : sectFirst_q;
                            eraseOut.last         <= (grpFirstOk_q || grpLastOk_q) ?
                                                     (grpLastOk_q ? grpLast_q : grpFirst_q) :
                                                     sectLast_q;
                            eraseOut.deselValid   <= deselOk_q;
                            eraseOut.deselAddr    <= desel_q;
                        end
                        sectFirstOk_q <= 1'b0;
                        sectLastOk_q  <= 1'b0;
                        grpFirstOk_q  <= 1'b0;
                        grpLastOk_q   <= 1'b0;
                        deselOk_q     <= 1'b0;
                    end
                    default: desel_q <= desel_q;
                endcase
            end
        end
    end

endmodule
